// >>> eitfe_front_end.sv
// The AXI4-Lite interface to the registers and the register addresses were left to the implementer.
`timescale 1ns/1ns
module eitfe_front_end #(
    parameter logic [3:0] TYPE_ID = eitfe_pkg::DEF_TYPE_ID,
    parameter int unsigned WR_CYCLES = eitfe_pkg::WR_CYC_DEF
) (
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic scl_pin,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    input wire logic hw_addr_bit2_pin,
    input wire logic hw_addr_bit1_pin,
    input wire logic hw_addr_bit0_pin,
    input wire logic wp_pin,
    input wire logic [eitfe_pkg::AXI_AW-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [eitfe_pkg::AXI_AW-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    import eitfe_pkg::*;

    // True when an aligned bus address selects the given register.
    function automatic logic addr_hit(input logic [AXI_AW-1:0] a, input logic [7:0] off);
        return {a[AXI_AW-1:2], 2'h0} == off;
    endfunction : addr_hit

    // True when an address word carries our type and hard-wired address.
    function automatic logic addr_match(input logic [7:0] w, input logic [2:0] hw);
        return (w[7:4] == TYPE_ID) && (w[3:1] == hw);
    endfunction : addr_match

    eitfe_pins_t pins_raw;
    eitfe_pins_t pins_s;
    eitfe_pins_t pins_q_ff;
    logic scl_rise;
    logic scl_fall;
    logic start_det;
    logic stop_det;
    logic wr_busy;
    logic wr_start;
    logic [2:0] hw_eff;
    logic csp_ff;
    logic nxt_csp;

    // Every pin passes two flops before any logic looks at it.
    assign pins_raw = '{scl: scl_pin, sda: sda_in, wp: wp_pin,
        hw_addr: {hw_addr_bit2_pin, hw_addr_bit1_pin, hw_addr_bit0_pin}};

    eitfe_sync #(.W($bits(eitfe_pins_t))) u_sync (
        .ref_clk(ref_clk),
        .rstn(rstn),
        .d(pins_raw),
        .q(pins_s)
    );

    eitfe_wr_timer #(.CYCLES(WR_CYCLES)) u_timer (
        .ref_clk(ref_clk),
        .rstn(rstn),
        .start(wr_start),
        .busy(wr_busy)
    );

    // Edge and bus condition detection on the synchronised pins.
    assign scl_rise = pins_s.scl && !pins_q_ff.scl;
    assign scl_fall = !pins_s.scl && pins_q_ff.scl;
    assign start_det = pins_s.scl && pins_q_ff.scl && pins_q_ff.sda && !pins_s.sda;
    assign stop_det = pins_s.scl && pins_q_ff.scl && !pins_q_ff.sda && pins_s.sda;
    // Pad bias pulls open address pins low; the chip-scale bit of the control register overrides them.
    assign hw_eff = csp_ff ? CSP_HW_ADDR : pins_s.hw_addr;

    eitfe_state_t state_ff;
    eitfe_state_t nxt_state;
    logic [3:0] bitcnt_ff;
    logic [3:0] nxt_bitcnt;
    logic [7:0] shift_ff;
    logic [7:0] nxt_shift;
    logic first_ff;
    logic nxt_first;
    logic rd_ff;
    logic nxt_rd;
    logic got_data_ff;
    logic nxt_got_data;
    logic [7:0] last_addr_ff;
    logic [7:0] nxt_last_addr;
    logic sda_oe_ff;
    logic nxt_sda_oe;
    logic sda_out_ff;

    // Bit framing, address decode and acknowledge control.
    always_comb begin
        nxt_state = state_ff;
        nxt_bitcnt = bitcnt_ff;
        nxt_shift = shift_ff;
        nxt_first = first_ff;
        nxt_rd = rd_ff;
        nxt_got_data = got_data_ff;
        nxt_last_addr = last_addr_ff;
        nxt_sda_oe = sda_oe_ff;
        wr_start = 1'b0;
        if (start_det) begin
            // A start always restarts framing, which also ends a recovery sequence.
            nxt_state = ST_RECV;
            nxt_bitcnt = '0;
            nxt_first = 1'b1;
            nxt_rd = 1'b0;
            nxt_got_data = 1'b0;
            nxt_sda_oe = 1'b0;
        end else if (stop_det) begin
            nxt_state = ST_STBY;
            nxt_sda_oe = 1'b0;
            // Only a write sequence with data and no protection commits.
            wr_start = !rd_ff && got_data_ff && !pins_s.wp;
            nxt_got_data = 1'b0;
        end else begin
            unique case (state_ff)
                ST_STBY, ST_READ, ST_WAIT: begin
                    nxt_sda_oe = 1'b0;
                end
                ST_RECV: begin
                    if (scl_rise && bitcnt_ff < BYTE_BITS) begin
                        nxt_shift = {shift_ff[6:0], pins_s.sda};
                        nxt_bitcnt = bitcnt_ff + 1'b1;
                    end else if (scl_fall && bitcnt_ff == BYTE_BITS) begin
                        if (!first_ff) begin
                            nxt_got_data = 1'b1;
                            nxt_state = ST_ACK;
                            nxt_sda_oe = 1'b1;
                        end else if (addr_match(shift_ff, hw_eff) && !wr_busy) begin
                            nxt_state = ST_ACK;
                            nxt_sda_oe = 1'b1;
                            nxt_rd = shift_ff[0];
                            nxt_last_addr = shift_ff;
                        end else begin
                            nxt_state = ST_WAIT;
                        end
                    end
                end
                ST_ACK: begin
                    if (scl_fall) begin
                        nxt_sda_oe = 1'b0;
                        nxt_bitcnt = '0;
                        nxt_first = 1'b0;
                        nxt_state = rd_ff ? ST_READ : ST_RECV;
                    end
                end
                default: begin
                    nxt_state = ST_STBY;
                    nxt_sda_oe = 1'b0;
                end
            endcase
        end
    end

    // Power-up lands in standby with the data line released.
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            pins_q_ff <= '0;
            state_ff <= ST_STBY;
            bitcnt_ff <= '0;
            shift_ff <= '0;
            first_ff <= 1'b0;
            rd_ff <= 1'b0;
            got_data_ff <= 1'b0;
            last_addr_ff <= '0;
            sda_oe_ff <= 1'b0;
            sda_out_ff <= 1'b0;
        end else begin
            pins_q_ff <= pins_s;
            state_ff <= nxt_state;
            bitcnt_ff <= nxt_bitcnt;
            shift_ff <= nxt_shift;
            first_ff <= nxt_first;
            rd_ff <= nxt_rd;
            got_data_ff <= nxt_got_data;
            last_addr_ff <= nxt_last_addr;
            sda_oe_ff <= nxt_sda_oe;
            sda_out_ff <= 1'b0;
        end
    end
    assign sda_oe = sda_oe_ff;
    assign sda_out = sda_out_ff;

    logic aw_hold_ff, nxt_aw_hold, w_hold_ff, nxt_w_hold;
    logic [AXI_AW-1:0] awaddr_ff, nxt_awaddr;
    logic [31:0] wdata_ff, nxt_wdata;
    logic wstrb0_ff, nxt_wstrb0;
    logic awready_ff, nxt_awready, wready_ff, nxt_wready;
    logic bvalid_ff, nxt_bvalid, arready_ff, nxt_arready, rvalid_ff, nxt_rvalid;
    logic [1:0] bresp_ff, nxt_bresp, rresp_ff, nxt_rresp;
    logic [31:0] rdata_ff, nxt_rdata, stat_word;

    // Status word shows standby, write busy, protect level and last address.
    // A rejected address word also rests the device until the next start.
    assign stat_word = {16'h0000, last_addr_ff, 5'h00, pins_s.wp, wr_busy,
        (state_ff == ST_STBY || state_ff == ST_WAIT) && !wr_busy};

    // AXI4-Lite slave: one write and one read under way at a time.
    always_comb begin
        nxt_aw_hold = aw_hold_ff;
        nxt_w_hold = w_hold_ff;
        nxt_awaddr = awaddr_ff;
        nxt_wdata = wdata_ff;
        nxt_wstrb0 = wstrb0_ff;
        nxt_bvalid = bvalid_ff;
        nxt_bresp = bresp_ff;
        nxt_csp = csp_ff;
        nxt_arready = arready_ff;
        nxt_rvalid = rvalid_ff;
        nxt_rdata = rdata_ff;
        nxt_rresp = rresp_ff;
        if (s_axi_awvalid && awready_ff) begin
            nxt_aw_hold = 1'b1;
            nxt_awaddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && wready_ff) begin
            nxt_w_hold = 1'b1;
            nxt_wdata = s_axi_wdata;
            nxt_wstrb0 = s_axi_wstrb[0];
        end
        if (bvalid_ff && s_axi_bready) begin
            nxt_bvalid = 1'b0;
        end
        if (aw_hold_ff && w_hold_ff && !bvalid_ff) begin
            nxt_aw_hold = 1'b0;
            nxt_w_hold = 1'b0;
            nxt_bvalid = 1'b1;
            nxt_bresp = RESP_OKAY;
            if (addr_hit(awaddr_ff, REG_CTRL)) begin
                if (wstrb0_ff) begin
                    nxt_csp = wdata_ff[CTRL_CSP];
                end
            end else if (!addr_hit(awaddr_ff, REG_STAT)) begin
                nxt_bresp = RESP_DECERR;
            end
        end
        nxt_awready = !nxt_aw_hold && !nxt_bvalid;
        nxt_wready = !nxt_w_hold && !nxt_bvalid;
        if (s_axi_arvalid && arready_ff) begin
            nxt_arready = 1'b0;
            nxt_rvalid = 1'b1;
            nxt_rresp = RESP_OKAY;
            nxt_rdata = 32'h0000_0000;
            if (addr_hit(s_axi_araddr, REG_CTRL)) begin
                nxt_rdata[CTRL_CSP] = csp_ff;
            end else if (addr_hit(s_axi_araddr, REG_STAT)) begin
                nxt_rdata = stat_word;
            end else begin
                nxt_rresp = RESP_DECERR;
            end
        end else if (rvalid_ff && s_axi_rready) begin
            nxt_rvalid = 1'b0;
            nxt_arready = 1'b1;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            aw_hold_ff <= 1'b0;
            w_hold_ff <= 1'b0;
            awaddr_ff <= '0;
            wdata_ff <= '0;
            wstrb0_ff <= 1'b0;
            awready_ff <= 1'b1;
            wready_ff <= 1'b1;
            bvalid_ff <= 1'b0;
            bresp_ff <= RESP_OKAY;
            csp_ff <= 1'b0;
            arready_ff <= 1'b1;
            rvalid_ff <= 1'b0;
            rdata_ff <= '0;
            rresp_ff <= RESP_OKAY;
        end else begin
            aw_hold_ff <= nxt_aw_hold;
            w_hold_ff <= nxt_w_hold;
            awaddr_ff <= nxt_awaddr;
            wdata_ff <= nxt_wdata;
            wstrb0_ff <= nxt_wstrb0;
            awready_ff <= nxt_awready;
            wready_ff <= nxt_wready;
            bvalid_ff <= nxt_bvalid;
            bresp_ff <= nxt_bresp;
            csp_ff <= nxt_csp;
            arready_ff <= nxt_arready;
            rvalid_ff <= nxt_rvalid;
            rdata_ff <= nxt_rdata;
            rresp_ff <= nxt_rresp;
        end
    end
    assign s_axi_awready = awready_ff;
    assign s_axi_wready = wready_ff;
    assign s_axi_bvalid = bvalid_ff;
    assign s_axi_bresp = bresp_ff;
    assign s_axi_arready = arready_ff;
    assign s_axi_rvalid = rvalid_ff;
    assign s_axi_rdata = rdata_ff;
    assign s_axi_rresp = rresp_ff;

    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rstn);

    // The address word is complete at the eighth falling clock.
    sequence seq_addr_done;
        scl_fall && state_ff == ST_RECV && bitcnt_ff == BYTE_BITS && first_ff;
    endsequence

    sequence seq_acked_low;
        sda_oe_ff && state_ff == ST_ACK;
    endsequence

    chk_start_frame: assert property (start_det |=> state_ff == ST_RECV && bitcnt_ff == 4'h0)
        else $error("start did not restart framing");
    chk_stop_standby: assert property (stop_det |=> state_ff == ST_STBY && !sda_oe_ff)
        else $error("stop did not return to standby");
    chk_addr_ack: assert property (seq_addr_done and addr_match(shift_ff, hw_eff)
        && !wr_busy && !start_det && !stop_det |=> seq_acked_low ##1 rd_ff == $past(shift_ff[0], 2))
        else $error("matching address not acknowledged");
    chk_addr_nack: assert property (seq_addr_done and !addr_match(shift_ff, hw_eff)
        && !start_det && !stop_det |=> state_ff == ST_WAIT && !sda_oe_ff)
        else $error("foreign address was acknowledged");
    chk_busy_nack: assert property (seq_addr_done and wr_busy |=> !sda_oe_ff)
        else $error("address acknowledged during internal write");
    chk_ack_release: assert property (seq_acked_low ##0 scl_fall && !start_det
        && !stop_det |=> !sda_oe_ff ##1 !sda_oe_ff)
        else $error("acknowledge not released after ninth clock");
    chk_oe_clock_low: assert property ($rose(sda_oe_ff) |-> !pins_s.scl && $past(scl_fall))
        else $error("data line driven outside clock low");
    chk_wp_blocks: assert property ($rose(wr_busy) |-> !$past(pins_s.wp))
        else $error("internal write started while protected");
    chk_bit_limit: assert property (bitcnt_ff <= BYTE_BITS)
        else $error("bit counter ran past a word");
endmodule : eitfe_front_end

// >>> eitfe_host_model.sv
`timescale 1ns/1ns
module eitfe_host_model (
    input wire logic ref_clk,
    input wire logic sda_wire,
    output logic scl_drv,
    output logic sda_pull
);
    logic scl_ff = 1'h1;
    logic pull_ff = 1'h0;

    // Idle bus: clock held high, data released to the pull-up.
    assign scl_drv = scl_ff;
    assign sda_pull = pull_ff;

    // A quarter of the 160 ns serial clock period.
    task automatic q();
        repeat (4) @(posedge ref_clk);
    endtask : q

    // Data falls while the clock is high, opening a frame.
    task automatic start_cond();
        pull_ff <= 1'h0;
        q();
        scl_ff <= 1'h1;
        q();
        pull_ff <= 1'h1;
        q();
        scl_ff <= 1'h0;
        q();
    endtask : start_cond

    // Data rises while the clock is high, closing a frame.
    task automatic stop_cond();
        pull_ff <= 1'h1;
        q();
        scl_ff <= 1'h1;
        q();
        pull_ff <= 1'h0;
        q();
        q();
    endtask : stop_cond

    // Data changes only in the low half; the wire is sampled mid-high.
    task automatic clock_bit(input logic b, output logic seen);
        pull_ff <= ~b;
        q();
        scl_ff <= 1'h1;
        q();
        seen = sda_wire;
        q();
        scl_ff <= 1'h0;
        q();
    endtask : clock_bit

    // Eight bits, most significant first, then a released ninth clock.
    task automatic send_byte(input logic [7:0] b, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            clock_bit(b[i], s);
        end
        clock_bit(1'h1, s);
        ack = (s === 1'h0);
    endtask : send_byte

    // Bus recovery: start, nine clocks, start, stop.
    task automatic recover();
        logic s;
        start_cond();
        repeat (9) clock_bit(1'h1, s);
        start_cond();
        stop_cond();
    endtask : recover
endmodule : eitfe_host_model

// >>> eitfe_pkg.sv
// Functional notes
// - Data changes only while clock low; a change while high is start or stop.
// - Data falling while clock high is a start; starts every command.
// - Data rising while clock high is a stop.
// - A stop ending a read sequence puts the device into standby.
// - Words are eight bits; device acknowledges each received word on ninth clock.
// - Standby at power-up and after stop once any internal write finished.
// - After that recovery sequence the device is idle and ready.
// - Each operation begins with an address word right after a start.
// - Address bits three to one compare with the three hard-wired pins.
// - Unconnected address pins read as low.
// - Chip-scale variant behaves as if pins read zero, zero, one.
// - Address word bit zero high selects read, low selects write.
// - A matching address word is acknowledged by pulling data low.
// - A mismatching address word gets no acknowledge; ignore bus until start.
// - Write-protect high forbids any change of the memory array.
// - Internal write from stop to completion lasts no more than 5 ms.
// - No address acknowledge while the internal write runs.
package eitfe_pkg;
    localparam int unsigned CLK_MHZ = 100;
    localparam int unsigned WR_TIME_MS = 5;
    localparam int unsigned WR_CYC_DEF = WR_TIME_MS * 1000 * CLK_MHZ;
    // Type identifier value is arbitrary.
    localparam logic [3:0] DEF_TYPE_ID = 4'h5;
    localparam logic [2:0] CSP_HW_ADDR = 3'h1;
    localparam logic [3:0] BYTE_BITS = 4'h8;
    localparam int unsigned AXI_AW = 8;
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_STAT = 8'h04;
    localparam int unsigned CTRL_CSP = 0;
    localparam int unsigned STAT_STBY = 0;
    localparam int unsigned STAT_BUSY = 1;
    localparam int unsigned STAT_WP = 2;
    localparam int unsigned STAT_ADDR = 8;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_DECERR = 2'h3;
    typedef struct packed {
        logic scl;
        logic sda;
        logic [2:0] hw_addr;
        logic wp;
    } eitfe_pins_t;
    typedef enum logic [2:0] {ST_STBY, ST_RECV, ST_ACK, ST_READ, ST_WAIT} eitfe_state_t;
endpackage : eitfe_pkg

// >>> eitfe_sync.sv
`timescale 1ns/1ns
module eitfe_sync #(
    parameter int W = 6
) (
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta_ff;
    logic [W-1:0] q_ff;

    // Two flops in a row; only the second stage is visible outside.
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            meta_ff <= '0;
            q_ff <= '0;
        end else begin
            meta_ff <= d;
            q_ff <= meta_ff;
        end
    end
    assign q = q_ff;
endmodule : eitfe_sync

// >>> eitfe_wr_timer.sv
`timescale 1ns/1ns
module eitfe_wr_timer #(
    parameter int unsigned CYCLES = eitfe_pkg::WR_CYC_DEF
) (
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic start,
    output logic busy
);
    import eitfe_pkg::*;
    localparam int CW = $clog2(CYCLES + 1);
    localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);
    logic [CW-1:0] cnt_ff;
    logic [CW-1:0] nxt_cnt;
    logic busy_ff;
    logic nxt_busy;

    // Busy for exactly CYCLES clocks after a start, never longer.
    always_comb begin
        nxt_cnt = cnt_ff;
        nxt_busy = busy_ff;
        if (busy_ff) begin
            nxt_cnt = cnt_ff + 1'b1;
            if (cnt_ff == LAST) begin
                nxt_busy = 1'b0;
                nxt_cnt = '0;
            end
        end else if (start) begin
            nxt_busy = 1'b1;
            nxt_cnt = '0;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            cnt_ff <= '0;
            busy_ff <= 1'b0;
        end else begin
            cnt_ff <= nxt_cnt;
            busy_ff <= nxt_busy;
        end
    end
    assign busy = busy_ff;

    chk_write_time_bound: assert property (@(posedge ref_clk) disable iff (!rstn)
        busy_ff |-> cnt_ff <= LAST)
        else $error("internal write lasts too long");
endmodule : eitfe_wr_timer

// >>> testbench.sv
`timescale 1ns/1ns
module testbench;
    import eitfe_pkg::*;
    localparam int unsigned WR = 400;
    logic ref_clk = 1'h0;
    logic rstn = 1'h0;
    logic [2:0] pins = 3'h0;
    logic wp = 1'h0;
    logic [3:0] wstrb = 4'hF;
    logic [7:0] awaddr = 8'h00;
    logic [7:0] araddr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic awvalid = 1'h0;
    logic wvalid = 1'h0;
    logic bready = 1'h0;
    logic arvalid = 1'h0;
    logic rready = 1'h0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    logic scl, pull, sda_wire, sda_out, sda_oe;
    int errors = 0;
    int check_count = 0;
    int cyc = 0;
    int busy_until = 0;
    logic csp_m = 1'h0;
    logic [7:0] last_a = 8'h00;
    logic [7:0] rnd = 8'h06;

    // Open-drain data wire with a pull-up.
    assign sda_wire = ~(pull | (sda_oe & ~sda_out));

    eitfe_host_model eitfe_host_model_inst (.ref_clk(ref_clk), .sda_wire(sda_wire),
        .scl_drv(scl), .sda_pull(pull));

    eitfe_front_end #(.WR_CYCLES(WR)) eitfe_front_end_inst (.ref_clk(ref_clk), .rstn(rstn),
        .scl_pin(scl), .sda_in(sda_wire), .sda_out(sda_out), .sda_oe(sda_oe),
        .hw_addr_bit2_pin(pins[2]), .hw_addr_bit1_pin(pins[1]), .hw_addr_bit0_pin(pins[0]),
        .wp_pin(wp), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));

    // Clock and the cycle count used by the write-busy model.
    initial begin
        forever #5 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk) cyc <= cyc + 1;

    function automatic logic [7:0] lfsr(logic [7:0] v);
        return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
    endfunction : lfsr

    // Expected acknowledge of an address word.
    function automatic logic exp_ack(logic [7:0] a);
        return a[7:4] == DEF_TYPE_ID && a[3:1] == (csp_m ? CSP_HW_ADDR : pins)
            && cyc >= busy_until;
    endfunction : exp_ack

    task automatic report(input logic [31:0] g, input logic [31:0] e);
        errors++;
        $display("Error at %0t: got %h expected %h", $time, g, e);
    endtask : report

    task automatic cmp_ack(input logic g, input logic e);
        check_count++;
        if (g !== e) report({31'h0, g}, {31'h0, e});
    endtask : cmp_ack

    task automatic cmp_word(input logic [31:0] g, input logic [31:0] e);
        check_count++;
        if (g !== e) report(g, e);
    endtask : cmp_word

    task automatic cmp_resp(input logic [1:0] g, input logic [1:0] e);
        check_count++;
        if (g !== e) report({30'h0, g}, {30'h0, e});
    endtask : cmp_resp

    // Write address and data offered together, each released when taken.
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        logic got;
        @(posedge ref_clk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        bready <= 1'h1;
        do begin
            @(posedge ref_clk);
            if (awready) awvalid <= 1'h0;
            if (wready) wvalid <= 1'h0;
            got = bvalid;
        end while (!got);
        r = bresp;
        bready <= 1'h0;
    endtask : axi_wr

    task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        logic got;
        @(posedge ref_clk);
        araddr <= a;
        arvalid <= 1'h1;
        rready <= 1'h1;
        do begin
            @(posedge ref_clk);
            if (arready) arvalid <= 1'h0;
            got = rvalid;
        end while (!got);
        d = rdata;
        r = rresp;
        rready <= 1'h0;
    endtask : axi_rd

    // Status word from the model: last address, protect, busy, standby.
    task automatic chk_stat();
        logic [31:0] d;
        logic [1:0] r;
        logic bz;
        axi_rd(REG_STAT, d, r);
        bz = cyc < busy_until;
        cmp_word(d, {16'h0000, last_a, 5'h00, wp, bz, !bz});
        cmp_resp(r, RESP_OKAY);
    endtask : chk_stat

    // One addressed frame with nd data bytes, then a stop.
    task automatic txn(input logic [7:0] a, input int nd);
        logic ok;
        logic got;
        eitfe_host_model_inst.start_cond();
        ok = exp_ack(a);
        eitfe_host_model_inst.send_byte(a, got);
        cmp_ack(got, ok);
        if (ok) last_a = a;
        for (int i = 0; i < nd; i++) begin
            rnd = lfsr(rnd);
            eitfe_host_model_inst.send_byte(rnd, got);
            cmp_ack(got, ok);
        end
        eitfe_host_model_inst.stop_cond();
        if (ok && !a[0] && nd > 0 && !wp) busy_until = cyc + WR;
    endtask : txn

    task automatic conclude();
        $display("Checks %0d, errors %0d", check_count, errors);
        if (errors == 0 && check_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : conclude

    // Main sequence.
    initial begin
        logic [31:0] d;
        logic [1:0] r;
        logic [7:0] a;
        logic [2:0] p;
        logic got;
        repeat (16) @(posedge ref_clk);
        rstn <= 1'h1;
        repeat (4) @(posedge ref_clk);
        chk_stat();
        axi_rd(REG_CTRL, d, r);
        cmp_word(d, 32'h0);
        axi_rd(8'h08, d, r);
        cmp_resp(r, RESP_DECERR);
        axi_wr(8'h08, 32'hFFFFFFFF, r);
        cmp_resp(r, RESP_DECERR);
        axi_wr(REG_STAT, 32'hFFFFFFFF, r);
        cmp_resp(r, RESP_OKAY);
        // Random straps and address words, about half of them matching.
        for (int i = 0; i < 12; i++) begin
            rnd = lfsr(rnd);
            p = (i == 0) ? 3'h0 : rnd[2:0];
            pins <= p;
            rnd = lfsr(rnd);
            a = rnd[7] ? {DEF_TYPE_ID, p, rnd[0]} : rnd;
            txn(a, 0);
        end
        chk_stat();
        // A write without byte lane zero leaves the mode alone; then chip-scale mode.
        wstrb <= 4'hE;
        axi_wr(REG_CTRL, 32'h1, r);
        cmp_resp(r, RESP_OKAY);
        axi_rd(REG_CTRL, d, r);
        cmp_word(d, 32'h0);
        wstrb <= 4'hF;
        axi_wr(REG_CTRL, 32'h1, r);
        cmp_resp(r, RESP_OKAY);
        csp_m = 1'h1;
        pins <= 3'h6;
        axi_rd(REG_CTRL, d, r);
        cmp_word(d, 32'h1);
        txn({DEF_TYPE_ID, 3'h6, 1'h0}, 0);
        txn({DEF_TYPE_ID, CSP_HW_ADDR, 1'h1}, 0);
        axi_wr(REG_CTRL, 32'h0, r);
        csp_m = 1'h0;
        // Write with data starts the internal write; polling is refused.
        txn({DEF_TYPE_ID, 3'h6, 1'h0}, 2);
        chk_stat();
        txn({DEF_TYPE_ID, 3'h6, 1'h1}, 0);
        while (cyc < busy_until + 20) @(posedge ref_clk);
        chk_stat();
        txn({DEF_TYPE_ID, 3'h6, 1'h1}, 0);
        // Write-protected write leaves the array alone.
        wp <= 1'h1;
        txn({DEF_TYPE_ID, 3'h6, 1'h0}, 1);
        chk_stat();
        wp <= 1'h0;
        // After a mismatch a valid word without a start is ignored.
        eitfe_host_model_inst.start_cond();
        eitfe_host_model_inst.send_byte(8'h00, got);
        cmp_ack(got, 1'h0);
        chk_stat();
        eitfe_host_model_inst.send_byte({DEF_TYPE_ID, 3'h6, 1'h0}, got);
        cmp_ack(got, 1'h0);
        eitfe_host_model_inst.stop_cond();
        // Interrupted frame, then bus recovery.
        eitfe_host_model_inst.start_cond();
        repeat (4) eitfe_host_model_inst.clock_bit(1'h0, got);
        eitfe_host_model_inst.recover();
        txn({DEF_TYPE_ID, 3'h6, 1'h0}, 0);
        chk_stat();
        conclude();
    end

    // Watchdog against a hung handshake.
    initial begin
        #200000;
        errors++;
        conclude();
    end
endmodule : testbench
